// >>> verilog/pfr_top.sv
`timescale 1ns/100ps
`include "pfr_params.svh"
module pfr_top #(
    parameter int unsigned NUM_CH = 2,
    parameter int unsigned OC_UNIT_CYC = `PFR_OC_UNIT_MS * `PFR_CLK_KHZ,
    parameter int unsigned RETRY_UNIT_CYC = `PFR_RETRY_UNIT_MS * `PFR_CLK_KHZ
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_page_in,
    input wire logic [15:0] restart_interval_setting_in,
    input wire logic [3:0] alert_mask_in,
    input wire logic [1:0] channel_run_pin_in,
    input wire logic [1:0] operation_on_in,
    input wire logic [1:0] oc_limit_in,
    input wire logic [1:0] ton_max_fault_in,
    input wire logic die_overtemp_in,
    output logic [15:0] cmd_rdata_out,
    output logic cmd_rvalid_out,
    output logic alert_out,
    output logic [1:0] out_enable_out
);
    pfr_pkg::pfr_top_st_t s_r;
    pfr_pkg::pfr_top_st_t s_nxt;
    logic [1:0] oc_flag;
    logic [1:0] ton_flag;
    logic [1:0] ot_flag;

    // ***************************************************
    // per-channel fault engines
    // ***************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            pfr_chan_if cif ();
            assign cif.oc_resp = s_r.oc_resp[g];
            assign cif.ton_resp = s_r.ton_resp[g];
            assign cif.restart_ivl = restart_interval_setting_in;
            assign cif.clear_faults = s_r.clr;
            assign cif.on_cmd = channel_run_pin_in[g] & operation_on_in[g];
            assign cif.run_pin = channel_run_pin_in[g];
            assign cif.oc_lvl = oc_limit_in[g];
            assign cif.ton_ev = ton_max_fault_in[g];
            assign cif.ot_lvl = die_overtemp_in;
            assign out_enable_out[g] = cif.out_en;
            assign oc_flag[g] = cif.oc_flag;
            assign ton_flag[g] = cif.ton_flag;
            assign ot_flag[g] = cif.ot_flag;
            pfr_chan #(
                .OC_UNIT_CYC(OC_UNIT_CYC),
                .RETRY_UNIT_CYC(RETRY_UNIT_CYC)
            ) u_chan (
                .core_clk_in(core_clk_in),
                .nrst_in(nrst_in),
                .ce_in(ce_in),
                .ch(cif)
            );
        end
    endgenerate

    // ***************************************************
    // status views, shared by byte and word reads
    // ***************************************************
    function automatic logic [7:0] status_byte(input logic p);
        logic [7:0] b;
        b = 8'h00;
        b[`PFR_SB_NOTA] = ton_flag[p] | ot_flag[p];
        b[`PFR_SB_CML] = s_r.cml;
        b[`PFR_SB_IOUT_OC] = oc_flag[p];
        return b;
    endfunction

    function automatic logic [15:0] status_word(input logic p);
        logic [15:0] w;
        w = {8'h00, status_byte(p)};
        w[`PFR_SW_VOUT] = ton_flag[p];
        w[`PFR_SW_IOUT] = oc_flag[p];
        w[`PFR_SW_MFR] = ot_flag[p];
        return w;
    endfunction

    // ***************************************************
    // command handling
    // ***************************************************
    always_comb begin
        logic p;
        logic bad_wr;
        p = cmd_page_in;
        bad_wr = 1'b0;
        s_nxt = s_r;
        s_nxt.clr = 1'b0;
        s_nxt.rvalid = 1'b0;
        if (cmd_wr_in) begin
            case (cmd_code_in)
                `PFR_CMD_OC_RESP: begin
                    // rejected values are not stored, the old byte stays
                    if (cmd_data_in[7:6] == `PFR_RESP_BAD) begin
                        bad_wr = 1'b1;
                    end else begin
                        s_nxt.oc_resp[p] = cmd_data_in;
                    end
                end
                `PFR_CMD_TON_RESP: s_nxt.ton_resp[p] = cmd_data_in;
                `PFR_CMD_OT_RESP: bad_wr = 1'b1;
                `PFR_CMD_CLEAR_FAULTS: begin
                    s_nxt.clr = 1'b1;
                    s_nxt.cml = 1'b0;
                end
                default: bad_wr = 1'b0;
            endcase
        end
        if (bad_wr) begin
            s_nxt.cml = 1'b1; // set wins over clear
        end
        if (cmd_rd_in) begin
            s_nxt.rvalid = 1'b1;
            case (cmd_code_in)
                `PFR_CMD_OC_RESP: s_nxt.rdata = {8'h00, s_r.oc_resp[p]};
                `PFR_CMD_TON_RESP: s_nxt.rdata = {8'h00, s_r.ton_resp[p]};
                `PFR_CMD_OT_RESP: s_nxt.rdata = {8'h00, `PFR_OT_RESP_VAL};
                `PFR_CMD_STATUS_BYTE: s_nxt.rdata = {8'h00, status_byte(p)};
                `PFR_CMD_STATUS_WORD: s_nxt.rdata = status_word(p);
                `PFR_CMD_STATUS_VOUT: s_nxt.rdata = {8'h00, 5'h00, ton_flag[p], 2'h0};
                `PFR_CMD_STATUS_IOUT: s_nxt.rdata = {8'h00, oc_flag[p], 7'h00};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
        // alert from any unmasked latched fault on either channel
        s_nxt.alert = (|ton_flag & ~alert_mask_in[0]) | (|oc_flag & ~alert_mask_in[1])
                    | (|ot_flag & ~alert_mask_in[2]) | (s_nxt.cml & ~alert_mask_in[3]);
    end

    // state register; nonvolatile copy is outside this block
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            s_r.oc_resp <= {`PFR_OC_RESP_RST, `PFR_OC_RESP_RST};
            s_r.ton_resp <= {`PFR_TON_RESP_RST, `PFR_TON_RESP_RST};
            s_r.cml <= 1'b0;
            s_r.clr <= 1'b0;
            s_r.rdata <= 16'h0000;
            s_r.rvalid <= 1'b0;
            s_r.alert <= 1'b0;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    assign cmd_rdata_out = s_r.rdata;
    assign cmd_rvalid_out = s_r.rvalid;
    assign alert_out = s_r.alert;
endmodule

// >>> inc/pfr_params.svh
`ifndef PFR_PARAMS_SVH
`define PFR_PARAMS_SVH

// ***************************************************
// command codes
// ***************************************************
`define PFR_CMD_CLEAR_FAULTS 8'h03
`define PFR_CMD_TON_RESP 8'h63
`define PFR_CMD_OC_RESP 8'h47
`define PFR_CMD_OT_RESP 8'hD6
`define PFR_CMD_STATUS_BYTE 8'h78
`define PFR_CMD_STATUS_WORD 8'h79
`define PFR_CMD_STATUS_VOUT 8'h7A
`define PFR_CMD_STATUS_IOUT 8'h7B

// ***************************************************
// reset values and fields
// ***************************************************
`define PFR_OC_RESP_RST 8'h00
`define PFR_OT_RESP_VAL 8'hC0
`define PFR_TON_RESP_RST 8'hB8
`define PFR_RESP_LIMIT 2'h0
`define PFR_RESP_BAD 2'h1
`define PFR_RESP_DELAYED 2'h2
`define PFR_RESP_NOW 2'h3
`define PFR_RETRY_FOREVER 3'h7
`define PFR_SB_NOTA 0
`define PFR_SB_CML 1
`define PFR_SB_IOUT_OC 4
`define PFR_SW_MFR 12
`define PFR_SW_IOUT 14
`define PFR_SW_VOUT 15
`define PFR_SV_TON_MAX 2
`define PFR_SI_OC 7

// ***************************************************
// timing
// ***************************************************
`define PFR_CLK_KHZ 50000
`define PFR_OC_UNIT_MS 16
`define PFR_RETRY_UNIT_MS 1

`endif

// >>> inc/pfr_pkg.sv
package pfr_pkg;
    typedef enum logic [2:0] {
        PFR_OFF = 3'b000,
        PFR_RUN = 3'b001,
        PFR_LIMIT = 3'b010,
        PFR_LATCH = 3'b011,
        PFR_RETRY = 3'b100
    } pfr_state_t;

    typedef struct packed {
        pfr_state_t st;
        logic [31:0] cnt;
        logic on_d;
        logic oc_flag;
        logic ton_flag;
        logic ot_flag;
        logic out_en;
    } pfr_chan_st_t;

    typedef struct packed {
        logic [1:0][7:0] oc_resp;
        logic [1:0][7:0] ton_resp;
        logic cml;
        logic clr;
        logic [15:0] rdata;
        logic rvalid;
        logic alert;
    } pfr_top_st_t;
endpackage

// >>> inc/pfr_chan_if.sv
`timescale 1ns/100ps
interface pfr_chan_if;
    logic [7:0] oc_resp;
    logic [7:0] ton_resp;
    logic [15:0] restart_ivl;
    logic clear_faults;
    logic on_cmd;
    logic run_pin;
    logic oc_lvl;
    logic ton_ev;
    logic ot_lvl;
    logic out_en;
    logic oc_flag;
    logic ton_flag;
    logic ot_flag;

    modport top (output oc_resp, ton_resp, restart_ivl, clear_faults, on_cmd, run_pin, oc_lvl, ton_ev, ot_lvl,
                 input out_en, oc_flag, ton_flag, ot_flag);
    modport chan (input oc_resp, ton_resp, restart_ivl, clear_faults, on_cmd, run_pin, oc_lvl, ton_ev, ot_lvl,
                  output out_en, oc_flag, ton_flag, ot_flag);
endinterface

// >>> verilog/pfr_chan.sv
`timescale 1ns/100ps
`include "pfr_params.svh"
module pfr_chan #(
    parameter int unsigned OC_UNIT_CYC = 800000,
    parameter int unsigned RETRY_UNIT_CYC = 50000
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    pfr_chan_if.chan ch
);
    pfr_pkg::pfr_chan_st_t s_r;
    pfr_pkg::pfr_chan_st_t s_nxt;

    // ***************************************************
    // fault state machine of one channel
    // ***************************************************
    // shared path into shutdown; retry 111 waits, anything else latches off
    function automatic pfr_pkg::pfr_chan_st_t shut(input pfr_pkg::pfr_chan_st_t v, input logic [2:0] retry,
                                                   input logic [15:0] ivl);
        pfr_pkg::pfr_chan_st_t r;
        r = v;
        if (retry == `PFR_RETRY_FOREVER) begin
            r.st = pfr_pkg::PFR_RETRY;
            r.cnt = 32'(ivl) * 32'(RETRY_UNIT_CYC);
        end else begin
            r.st = pfr_pkg::PFR_LATCH;
            r.cnt = 32'h0000_0000;
        end
        return r;
    endfunction

    always_comb begin
        logic cycled;
        cycled = 1'b0;
        s_nxt = s_r;
        cycled = ch.on_cmd & ~s_r.on_d;
        s_nxt.on_d = ch.on_cmd;
        // flags: set beats clear in the same cycle
        if (ch.clear_faults | cycled) begin
            s_nxt.oc_flag = 1'b0;
            s_nxt.ton_flag = 1'b0;
            s_nxt.ot_flag = 1'b0;
        end
        if (ch.oc_lvl & s_r.out_en) begin
            s_nxt.oc_flag = 1'b1;
        end
        if (ch.ton_ev) begin
            s_nxt.ton_flag = 1'b1;
        end
        if (ch.ot_lvl) begin
            s_nxt.ot_flag = 1'b1;
        end
        case (s_r.st)
            pfr_pkg::PFR_OFF: begin
                if (ch.on_cmd) begin
                    s_nxt.st = pfr_pkg::PFR_RUN;
                end
            end
            pfr_pkg::PFR_RUN: begin
                if (!ch.on_cmd) begin
                    s_nxt.st = pfr_pkg::PFR_OFF;
                end else if (ch.ton_ev && ch.ton_resp != 8'h00) begin
                    s_nxt = shut(s_nxt, ch.ton_resp[5:3], ch.restart_ivl);
                end else if (ch.oc_lvl) begin
                    case (ch.oc_resp[7:6])
                        `PFR_RESP_DELAYED: begin
                            s_nxt.st = pfr_pkg::PFR_LIMIT;
                            s_nxt.cnt = 32'(ch.oc_resp[2:0]) * 32'(OC_UNIT_CYC);
                        end
                        `PFR_RESP_NOW: s_nxt = shut(s_nxt, ch.oc_resp[5:3], ch.restart_ivl);
                        default: s_nxt.st = pfr_pkg::PFR_RUN; // brick-wall limiting is analog
                    endcase
                end
            end
            pfr_pkg::PFR_LIMIT: begin
                if (!ch.on_cmd) begin
                    s_nxt.st = pfr_pkg::PFR_OFF;
                end else if (!ch.oc_lvl) begin
                    s_nxt.st = pfr_pkg::PFR_RUN;
                end else if (s_r.cnt == 32'h0000_0000) begin
                    s_nxt = shut(s_nxt, ch.oc_resp[5:3], ch.restart_ivl);
                end else begin
                    s_nxt.cnt = s_r.cnt - 32'h0000_0001;
                end
            end
            pfr_pkg::PFR_LATCH: begin
                // only the run pin going low releases it
                if (!ch.run_pin) begin
                    s_nxt.st = pfr_pkg::PFR_OFF;
                end
            end
            pfr_pkg::PFR_RETRY: begin
                if (!ch.on_cmd) begin
                    s_nxt.st = pfr_pkg::PFR_OFF;
                end else if (s_r.cnt == 32'h0000_0000) begin
                    s_nxt.st = pfr_pkg::PFR_RUN;
                end else begin
                    s_nxt.cnt = s_r.cnt - 32'h0000_0001;
                end
            end
            default: s_nxt.st = pfr_pkg::PFR_OFF;
        endcase
        // die overtemp response is fixed at 11: off while hot only
        s_nxt.out_en = (s_nxt.st == pfr_pkg::PFR_RUN || s_nxt.st == pfr_pkg::PFR_LIMIT) & ~ch.ot_lvl;
    end

    // state register
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            s_r <= '0;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    assign ch.out_en = s_r.out_en;
    assign ch.oc_flag = s_r.oc_flag;
    assign ch.ton_flag = s_r.ton_flag;
    assign ch.ot_flag = s_r.ot_flag;
endmodule

// >>> testbench/pfr_top_assertions.sv
`timescale 1ns/100ps
module pfr_top_assertions (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_page_in,
    input wire logic [3:0] alert_mask_in,
    input wire logic [1:0] channel_run_pin_in,
    input wire logic [1:0] operation_on_in,
    input wire logic [1:0] oc_limit_in,
    input wire logic [1:0] ton_max_fault_in,
    input wire logic die_overtemp_in,
    input wire logic [15:0] cmd_rdata_out,
    input wire logic cmd_rvalid_out,
    input wire logic alert_out,
    input wire logic [1:0] out_enable_out
);
    // ****
    // shadow of channel 0 response code
    // ****
    logic [1:0] resp0_r;
    logic hit0;
    // refused code 01 never lands, so the shadow skips it too
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            resp0_r <= 2'h0;
        end else if (ce_in && cmd_wr_in && cmd_code_in == 8'h47 && !cmd_page_in && cmd_data_in[7:6] != 2'h1) begin
            resp0_r <= cmd_data_in[7:6];
        end
    end
    // channel 0 running into its limit
    assign hit0 = out_enable_out[0] & oc_limit_in[0];
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // channel flag lands first, alert follows one cycle later; cml and its alert land on the same edge
    sequence s_alert_late;
        ##1 alert_out;
    endsequence
    a_rd_answer: assert property (ce_in && cmd_rd_in |=> cmd_rvalid_out)
        else $error("read not answered");
    a_rv_cause: assert property (cmd_rvalid_out |-> $past(cmd_rd_in))
        else $error("answer without read");
    a_ot_readonly: assert property (ce_in && cmd_rd_in && cmd_code_in == 8'hD6 |=> cmd_rdata_out == 16'h00C0)
        else $error("die overtemp response wrong");
    a_oc_alert: assert property (hit0 && !alert_mask_in[1] |=> s_alert_late)
        else $error("overcurrent alert missing");
    a_ton_alert: assert property (ton_max_fault_in[0] && !alert_mask_in[0] |=> s_alert_late)
        else $error("timeout alert missing");
    a_cml_alert: assert property (cmd_wr_in && cmd_code_in == 8'hD6 && !alert_mask_in[3] |=> s_alert_late)
        else $error("comm fault alert missing");
    a_ot_off: assert property (die_overtemp_in |=> out_enable_out == 2'h0)
        else $error("output on while hot");
    a_oc_shut: assert property (resp0_r == 2'h3 && hit0 |=> !out_enable_out[0])
        else $error("no immediate shutdown");
    a_oc_keep: assert property (resp0_r == 2'h0 && hit0 && channel_run_pin_in[0] && operation_on_in[0] &&
        !die_overtemp_in |=> out_enable_out[0])
        else $error("limit mode stopped");
endmodule
bind pfr_top pfr_top_assertions u_pfr_top_assertions (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .cmd_wr_in(cmd_wr_in),
    .cmd_rd_in(cmd_rd_in),
    .cmd_code_in(cmd_code_in),
    .cmd_data_in(cmd_data_in),
    .cmd_page_in(cmd_page_in),
    .alert_mask_in(alert_mask_in),
    .channel_run_pin_in(channel_run_pin_in),
    .operation_on_in(operation_on_in),
    .oc_limit_in(oc_limit_in),
    .ton_max_fault_in(ton_max_fault_in),
    .die_overtemp_in(die_overtemp_in),
    .cmd_rdata_out(cmd_rdata_out),
    .cmd_rvalid_out(cmd_rvalid_out),
    .alert_out(alert_out),
    .out_enable_out(out_enable_out)
);

// >>> testbench/pfr_host_model.sv
`timescale 1ns/100ps
module pfr_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] code_out,
    output logic [7:0] data_out,
    output logic page_out
);
    // ****
    // host command engine
    // ****
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        code_out = 8'h00;
        data_out = 8'h00;
        page_out = 1'b0;
    end
    // one strobe per command; idle bus inverted so stale data never looks valid
    task automatic cmd(input logic w, input logic p, input logic [7:0] c, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= w;
        rd_out <= !w;
        page_out <= p;
        code_out <= c;
        data_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        code_out <= ~c;
        data_out <= ~d;
    endtask
    // answer is due exactly one cycle after the taking edge
    task automatic rd(input logic p, input logic [7:0] c, output logic [15:0] q);
        cmd(1'b0, p, c, 8'h00);
        @(posedge clk_in);
        q = rvalid_in ? rdata_in : 16'hXXXX;
    endtask
endmodule

// >>> testbench/pfr_top_tb.sv
`timescale 1ns/100ps
module pfr_top_tb;
    logic core_clk, nrst, ce, wr, rd, page, ot, rvalid, alert;
    logic [7:0] code, data;
    logic [15:0] ivl, rdata, q;
    logic [3:0] mask;
    logic [1:0] run, op, ocl, ton, oen;
    int mismatches, checks;

    // short units keep delays and retry gaps to a few cycles
    pfr_top #(.OC_UNIT_CYC(10), .RETRY_UNIT_CYC(5)) u_pfr_top (
        .core_clk_in(core_clk), .nrst_in(nrst), .ce_in(ce), .cmd_wr_in(wr), .cmd_rd_in(rd),
        .cmd_code_in(code), .cmd_data_in(data), .cmd_page_in(page), .restart_interval_setting_in(ivl),
        .alert_mask_in(mask), .channel_run_pin_in(run), .operation_on_in(op), .oc_limit_in(ocl),
        .ton_max_fault_in(ton), .die_overtemp_in(ot), .cmd_rdata_out(rdata), .cmd_rvalid_out(rvalid),
        .alert_out(alert), .out_enable_out(oen));
    pfr_host_model u_pfr_host_model (.clk_in(core_clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .wr_out(wr), .rd_out(rd), .code_out(code), .data_out(data), .page_out(page));

    // ****
    // clock and helpers
    // ****
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmpb(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic wrc(input logic p, input logic [7:0] c, input logic [7:0] d);
        u_pfr_host_model.cmd(1'b1, p, c, d);
    endtask
    task automatic rdv(input logic p, input logic [7:0] c, input logic [15:0] e, input string n);
        u_pfr_host_model.rd(p, c, q);
        cmp16(n, e, q);
    endtask
    task automatic rdb(input logic p, input logic [7:0] c, input int b, input logic e, input string n);
        u_pfr_host_model.rd(p, c, q);
        cmpb(n, e, q[b]);
    endtask
    // clear lands two edges late and alert one more, so allow five
    task automatic clr;
        wrc(1'b0, 8'h03, 8'h00);
        cyc(5);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_defaults;
        rdv(1'b0, 8'h47, 16'h0000, "oc resp ch0");
        rdv(1'b1, 8'h47, 16'h0000, "oc resp ch1");
        rdv(1'b0, 8'hD6, 16'h00C0, "die ot resp");
        wrc(1'b0, 8'h47, 8'h40);
        wrc(1'b0, 8'hD6, 8'h00);
        rdv(1'b0, 8'h47, 16'h0000, "oc resp kept");
        rdv(1'b0, 8'hD6, 16'h00C0, "die ot kept");
        rdb(1'b0, 8'h78, 1, 1'b1, "cml bit");
        cmpb("cml alert", 1'b1, alert);
        clr;
        cmpb("alert cleared", 1'b0, alert);
        $display("t_defaults done");
    endtask
    task automatic t_ton;
        wrc(1'b0, 8'h63, 8'h00);
        @(posedge core_clk);
        ton <= 2'b01;
        @(posedge core_clk);
        ton <= 2'b00;
        cyc(3);
        cmpb("ton alert", 1'b1, alert);
        cmpb("ton zero keeps on", 1'b1, oen[0]);
        rdb(1'b0, 8'h78, 0, 1'b1, "none of above");
        rdb(1'b0, 8'h79, 15, 1'b1, "vout bit");
        rdb(1'b0, 8'h7A, 2, 1'b1, "timeout bit");
        rdb(1'b1, 8'h7A, 2, 1'b0, "timeout ch1");
        clr;
        $display("t_ton done");
    endtask
    task automatic t_overtemp;
        @(posedge core_clk);
        ot <= 1'b1;
        cyc(3);
        cmp16("hot off", 16'h0000, {14'h0000, oen});
        rdb(1'b0, 8'h79, 12, 1'b1, "die ot bit");
        ot <= 1'b0;
        cyc(4);
        cmp16("cool resume", 16'h0003, {14'h0000, oen});
        clr;
        $display("t_overtemp done");
    endtask
    task automatic t_limit;
        @(posedge core_clk);
        ocl <= 2'b01;
        cyc(6);
        cmpb("limit runs on", 1'b1, oen[0]);
        cmpb("oc alert", 1'b1, alert);
        ocl <= 2'b00;
        rdb(1'b0, 8'h78, 4, 1'b1, "iout_oc bit");
        rdb(1'b0, 8'h79, 14, 1'b1, "iout bit");
        rdb(1'b0, 8'h7B, 7, 1'b1, "oc bit held");
        rdb(1'b1, 8'h7B, 7, 1'b0, "oc bit ch1");
        clr;
        rdb(1'b0, 8'h7B, 7, 1'b0, "oc bit cleared");
        $display("t_limit done");
    endtask
    task automatic t_delay;
        wrc(1'b0, 8'h47, 8'h82);
        @(posedge core_clk);
        ocl <= 2'b01;
        cyc(15);
        cmpb("delay still on", 1'b1, oen[0]);
        cyc(10);
        cmpb("delay then off", 1'b0, oen[0]);
        ocl <= 2'b00;
        cyc(10);
        cmpb("no restart", 1'b0, oen[0]);
        run <= 2'b10;
        cyc(3);
        run <= 2'b11;
        cyc(4);
        cmpb("run pin restart", 1'b1, oen[0]);
        rdb(1'b0, 8'h7B, 7, 1'b0, "oc bit after run cycle");
        $display("t_delay done");
    endtask
    // clock enable low must swallow a timeout pulse; then a real one on ch1 (response B8h)
    task automatic t_freeze;
        @(posedge core_clk);
        ce <= 1'b0;
        ton <= 2'b10;
        @(posedge core_clk);
        ton <= 2'b00;
        cyc(2);
        ce <= 1'b1;
        cyc(3);
        cmpb("frozen alert", 1'b0, alert);
        cmpb("frozen run", 1'b1, oen[1]);
        ton <= 2'b10;
        @(posedge core_clk);
        ton <= 2'b00;
        cyc(1);
        cmpb("ton ch1 shut", 1'b0, oen[1]);
        cyc(12);
        cmpb("ton ch1 retry", 1'b1, oen[1]);
        clr;
        $display("t_freeze done");
    endtask
    task automatic t_now;
        wrc(1'b0, 8'h47, 8'hF8);
        wrc(1'b1, 8'h47, 8'hC0);
        rdv(1'b1, 8'h47, 16'h00C0, "oc resp ch1 stored");
        @(posedge core_clk);
        ocl <= 2'b11;
        cyc(2);
        cmp16("shut now", 16'h0000, {14'h0000, oen});
        ocl <= 2'b00;
        cyc(6);
        cmpb("retry wait", 1'b0, oen[0]);
        cyc(10);
        cmp16("retry ch0 only", 16'h0001, {14'h0000, oen});
        $display("t_now done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        run = 2'b11;
        op = 2'b11;
        ocl = 2'b00;
        ton = 2'b00;
        ot = 1'b0;
        mask = 4'h0;
        ivl = 16'h0002;
        cyc(3);
        nrst <= 1'b1;
        t_defaults;
        t_ton;
        t_overtemp;
        t_limit;
        t_delay;
        t_freeze;
        t_now;
        wrap_up;
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        cyc(5000);
        mismatches++;
        wrap_up;
    end
endmodule
